// File: dmsc_peer_model.sv
// Purpose: peer serial controller on the line side of the channel
// Assumes: async frames, one start bit, one stop bit, lsb first
// Notes: bit length comes from the bench in clk_sys cycles
`timescale 1ns/1ps
`default_nettype none
module dmsc_peer_model
(
  input wire logic clk_sys,
  input wire logic tx_pin,
  input wire logic listen,
  input wire logic [9:0] bit_cyc,
  output logic rx_pin,
  output logic clear_to_send_n,
  output logic word_valid,
  output logic [7:0] word
);
  // =========================================================
  // line driver
  // idle levels: line high, sender allowed
  initial
  begin
    rx_pin = 1'b1;
    clear_to_send_n = 1'b0;
    word_valid = 1'b0;
    word = 8'h00;
  end

  // one level held for a whole bit
  task automatic put_bit(input logic v);
    @(posedge clk_sys);
    rx_pin <= v;
    repeat (bit_cyc - 10'h001) @(posedge clk_sys);
  endtask : put_bit

  // start, eight or nine data bits lsb first, stop
  task automatic send(input logic [8:0] d, input logic nine);
    put_bit(1'b0);
    for (int i = 0; i < 9; i++)
      if (i < 8 || nine)
        put_bit(d[i]);
    put_bit(1'b1);
  endtask : send

  // low pulse far shorter than a start bit
  task automatic dip(input int n);
    @(posedge clk_sys);
    rx_pin <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rx_pin <= 1'b1;
  endtask : dip

  // receiver side asks the sender to pause or go on
  task automatic set_hold(input logic v);
    @(posedge clk_sys);
    clear_to_send_n <= v;
  endtask : set_hold

  // =========================================================
  // frame receiver
  // samples each bit at its centre, reports at stop centre
  always
  begin
    @(negedge tx_pin);
    repeat (bit_cyc + bit_cyc / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++)
    begin
      word[i] = tx_pin;
      repeat (bit_cyc) @(posedge clk_sys);
    end
    if (listen)
      word_valid <= 1'b1;
    @(posedge clk_sys);
    word_valid <= 1'b0;
  end
endmodule : dmsc_peer_model
`default_nettype wire

// File: dmsc_pkg.sv
// Purpose: shared constants for the dual mode serial channel
// Assumes: 8-bit register port, 3-bit register address
// Notes: register offsets and bit positions are fixed here only
`default_nettype none
package dmsc_pkg;
  // =========================================================
  // register map
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] ADDR_DATA = 3'h0; // serial_data_buffer
  localparam logic [2:0] ADDR_CTRL = 3'h1; // serial_control_reg
  localparam logic [2:0] ADDR_MODE = 3'h2; // serial_mode_reg
  localparam logic [2:0] ADDR_BRCR = 3'h3; // divider_n, frac enable
  localparam logic [2:0] ADDR_BRADD = 3'h4; // divider_k
  localparam logic [2:0] ADDR_STAT = 3'h5; // busy and buffer state
  // =========================================================
  // field positions
  localparam int MB_TB8 = 7;
  localparam int MB_HS = 6;
  localparam int MB_RXE = 5;
  localparam int MB_WU = 4;
  localparam int CB_NINTH = 7;
  localparam int CB_PE = 5;
  localparam int CB_OERR = 4;
  localparam int CB_EDGE = 1;
  localparam int CB_DIR = 0;
  localparam int BB_FRAC = 6;
  localparam logic [7:0] CTRL_WMASK = 8'h23;
  localparam logic [7:0] REG_RST = 8'h00;
  // =========================================================
  // modes, clock sources, counts
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_7 = 2'h1;
  localparam logic [1:0] MODE_8 = 2'h2;
  localparam logic [1:0] MODE_9 = 2'h3;
  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_BRG = 2'h1;
  localparam logic [1:0] SRC_IO = 2'h2;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SAMP_FIRST = 4'h6; // 7th base clock
  localparam logic [3:0] SAMP_LAST = 4'h8; // 9th base clock
  localparam logic [3:0] TICK_RISE = 4'h8;
  localparam logic [3:0] TICK_FALL = 4'h0;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [4:0] FRAC_BASE = 5'h10;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } dmsc_rx_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } dmsc_tx_t;

  // bits per async frame between start and stop
  function automatic logic [3:0] frame_bits(input logic [1:0] mode,
                                            input logic pe);
    frame_bits = (mode == MODE_9) ? 4'h9 :
                 (mode == MODE_8) ? (4'h8 + {3'h0, pe}) :
                 (4'h7 + {3'h0, pe});
  endfunction : frame_bits
endpackage : dmsc_pkg
`default_nettype wire

// File: dmsc_serial_channel.sv
// Purpose: dual mode serial channel, shift mode and async frames
// Assumes: prescaler tap, io and timer ticks are clk_sys pulses
// Notes: pins from outside pass two flip-flops before use
//
// How it works
// - integer divider divides prescaler tap by N, zero meaning sixteen
// - fractional option stretches 16-K of every 16 periods by one in async modes, not in shift mode
// - async mode may use the timer match pulse as base clock
// - shift mode never uses the timer match pulse
// - shift mode, own clock: rate output halved, driven on pin
// - shift mode, input clock: pin edges sample and shift directly, no base clock
// - async base clock picked from four sources by two bits
// - sixteen base clocks per bit, samples 7,8,9, majority wins
// - frame begins only if start bit majority is low
// - shift mode samples receive pin on selected clock edge
// - collected word moves to second buffer, receive interrupt
// - overrun drops new word, keeps buffer and ninth bit
// - ninth bit flag holds parity of 8-bit frames or data bit eight
// - in 9-bit mode, wakeup filter raises receive interrupt only for frames with ninth bit one
// - transmit counter gives one bit tick per sixteen base clocks
// - shift mode drives one transmit bit per clock period, on the non-sampling edge
// - async send starts on next rising edge of bit tick
// - clear-to-send high holds next frame, no interrupt until its stop bit starts
// - held frame starts on first falling edge of bit tick
// - data sent LSB first; buffer empties and interrupts as stop bit starts
`timescale 1ns/1ps
`default_nettype none
module dmsc_serial_channel
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [dmsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dmsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dmsc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic presc_tick,
  input wire logic io_tick,
  input wire logic timer_match_tick,
  input wire logic rx_pin,
  input wire logic serial_clock_pin_i,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  input wire logic clear_to_send_n,
  output logic tx_pin,
  output logic rx_irq,
  output logic tx_irq
);
  import dmsc_pkg::*;

  typedef struct packed {
    logic [7:0] mode; logic [7:0] ctrl; logic [7:0] brcr;
    logic [3:0] bradd; logic [7:0] rdata;
    logic [4:0] brg_cnt; logic [3:0] brg_ph; logic brg_tick;
    logic [7:0] tx_buf; logic tx_full; logic [7:0] rx_buf;
    logic rx_full; logic ninth; logic oerr;
    dmsc_rx_t rx_st; logic [3:0] rx_cnt; logic [1:0] rx_ones;
    logic [3:0] rx_bits; logic [8:0] rx_sr;
    dmsc_tx_t tx_st; logic [3:0] tx_cnt; logic tx_ph; logic tx_held;
    logic [8:0] tx_sr; logic [3:0] tx_bits; logic tx_pin;
    logic sy_act; logic sy_tx; logic [3:0] sy_bits; logic [7:0] sy_sr;
    logic sclk_o; logic sclk_oe;
    logic rx_irq; logic tx_irq;
    logic rx_s1; logic rx_s2; logic ck_s1; logic ck_s2; logic ck_s3;
    logic cts_s1; logic cts_s2;
  } dmsc_state_t;

  dmsc_state_t s_q;
  dmsc_state_t s_d;
  logic base_tick;
  logic xfer;
  logic [8:0] xword;

  // =========================================================
  // state update
  // next state, all behaviour
  always_comb
  begin
    logic [1:0] mode;
    logic [3:0] nbits;
    logic [4:0] term;
    logic async_m;
    logic ck_rise;
    logic ck_fall;
    logic samp;
    logic shft;
    logic rise;
    logic fall;
    logic adv;
    logic bitv;
    logic [1:0] ones;
    logic [8:0] sr_n;
    logic rd_buf;
    s_d = s_q;
    sr_n = 9'h000;
    mode = s_q.mode[3:2];
    async_m = (mode != MODE_SYNC);
    nbits = frame_bits(mode, s_q.ctrl[CB_PE]);
    xfer = 1'b0;
    xword = 9'h000;
    s_d.rx_irq = 1'b0;
    s_d.tx_irq = 1'b0;
    s_d.brg_tick = 1'b0;
    // two-stage synchronisers, third stage for edges
    s_d.rx_s1 = rx_pin;
    s_d.rx_s2 = s_q.rx_s1;
    s_d.ck_s1 = serial_clock_pin_i;
    s_d.ck_s2 = s_q.ck_s1;
    s_d.ck_s3 = s_q.ck_s2;
    s_d.cts_s1 = clear_to_send_n;
    s_d.cts_s2 = s_q.cts_s1;
    ck_rise = s_q.ck_s2 & ~s_q.ck_s3;
    ck_fall = ~s_q.ck_s2 & s_q.ck_s3;
    // rate generator
    term = (s_q.brcr[3:0] == 4'h0) ? 5'h0f : {1'b0, s_q.brcr[3:0] - 4'h1};
    if (s_q.brcr[BB_FRAC] && async_m &&
        ({1'b0, s_q.brg_ph} < (FRAC_BASE - {1'b0, s_q.bradd})))
      term = term + 5'h01;
    if (presc_tick)
    begin
      if (s_q.brg_cnt >= term)
      begin
        s_d.brg_cnt = 5'h00;
        s_d.brg_tick = 1'b1;
      end
      else
        s_d.brg_cnt = s_q.brg_cnt + 5'h01;
    end
    if (s_q.brg_tick)
      s_d.brg_ph = s_q.brg_ph + 4'h1;
    // async base clock selection, none in shift mode
    unique case (s_q.mode[1:0])
      SRC_TIMER: base_tick = timer_match_tick;
      SRC_BRG: base_tick = s_q.brg_tick;
      SRC_IO: base_tick = io_tick;
      SRC_EXT: base_tick = ck_rise;
    endcase
    base_tick = base_tick & async_m;
    // =======================================================
    // async receiver
    ones = s_q.rx_ones;
    if (s_q.rx_cnt >= SAMP_FIRST && s_q.rx_cnt <= SAMP_LAST && s_q.rx_s2)
      ones = ones + 2'h1;
    bitv = ones[1];
    if (base_tick)
    begin
      s_d.rx_cnt = s_q.rx_cnt + 4'h1;
      s_d.rx_ones = ones;
      if (s_q.rx_cnt == OVS_LAST)
        s_d.rx_ones = 2'h0;
      unique case (s_q.rx_st)
        RX_IDLE:
        begin
          s_d.rx_cnt = 4'h1;
          s_d.rx_ones = 2'h0;
          if (s_q.mode[MB_RXE] && !s_q.rx_s2)
            s_d.rx_st = RX_START;
        end
        RX_START:
        begin
          if (s_q.rx_cnt == SAMP_LAST && bitv)
            s_d.rx_st = RX_IDLE;
          if (s_q.rx_cnt == OVS_LAST)
          begin
            s_d.rx_st = RX_DATA;
            s_d.rx_bits = 4'h0;
          end
        end
        RX_DATA:
        begin
          if (s_q.rx_cnt == SAMP_LAST)
          begin
            sr_n = {bitv, s_q.rx_sr[8:1]};
            s_d.rx_sr = sr_n;
            s_d.rx_bits = s_q.rx_bits + 4'h1;
            if (s_q.rx_bits + 4'h1 == nbits)
            begin
              xfer = 1'b1;
              xword = sr_n >> (4'h9 - nbits);
              if (nbits != 4'h9)
                xword[8] = 1'b0;
            end
          end
          if (s_q.rx_cnt == OVS_LAST && s_q.rx_bits == nbits)
            s_d.rx_st = RX_STOP;
        end
        RX_STOP:
          if (s_q.rx_cnt == SAMP_LAST)
            s_d.rx_st = RX_IDLE;
      endcase
    end
    // =======================================================
    // async transmitter, bit tick from counter
    rise = 1'b0;
    fall = 1'b0;
    if (base_tick)
    begin
      s_d.tx_cnt = s_q.tx_cnt + 4'h1;
      rise = (s_d.tx_cnt == TICK_RISE);
      fall = (s_d.tx_cnt == TICK_FALL);
    end
    adv = s_q.tx_ph ? fall : rise;
    if (async_m)
    begin
      unique case (s_q.tx_st)
        TX_IDLE:
          if (s_q.tx_full)
          begin
            if (s_q.mode[MB_HS] && s_q.cts_s2)
              s_d.tx_held = 1'b1;
            else if (s_q.tx_held ? fall : rise)
            begin
              s_d.tx_st = TX_START;
              s_d.tx_ph = s_q.tx_held;
              s_d.tx_held = 1'b0;
              s_d.tx_pin = 1'b0;
              s_d.tx_sr = {s_q.mode[MB_TB8], s_q.tx_buf};
            end
          end
        TX_START, TX_DATA:
          if (adv)
          begin
            s_d.tx_st = TX_DATA;
            if (s_q.tx_st == TX_DATA && s_q.tx_bits == nbits)
            begin
              s_d.tx_st = TX_STOP;
              s_d.tx_pin = 1'b1;
              s_d.tx_full = 1'b0;
              s_d.tx_irq = 1'b1;
            end
            else
            begin
              s_d.tx_pin = s_q.tx_sr[0];
              s_d.tx_sr = {1'b1, s_q.tx_sr[8:1]};
              s_d.tx_bits = (s_q.tx_st == TX_START) ? 4'h1 :
                            s_q.tx_bits + 4'h1;
            end
          end
        TX_STOP:
          if (adv)
            s_d.tx_st = TX_IDLE;
      endcase
    end
    // =======================================================
    // shift mode transfers
    s_d.sclk_oe = ~async_m & ~s_q.ctrl[CB_DIR];
    rise = ck_rise;
    fall = ck_fall;
    if (!s_q.ctrl[CB_DIR])
    begin
      rise = 1'b0;
      fall = 1'b0;
      if (s_q.sy_act && s_q.brg_tick)
      begin
        s_d.sclk_o = ~s_q.sclk_o;
        rise = ~s_q.sclk_o;
        fall = s_q.sclk_o;
      end
    end
    samp = s_q.ctrl[CB_EDGE] ? fall : rise;
    shft = s_q.ctrl[CB_EDGE] ? rise : fall;
    if (!async_m)
    begin
      if (!s_q.sy_act)
      begin
        s_d.sclk_o = 1'b1;
        if (s_q.tx_full || s_q.mode[MB_RXE])
        begin
          s_d.sy_act = 1'b1;
          s_d.sy_tx = s_q.tx_full;
          s_d.sy_bits = 4'h0;
          s_d.tx_pin = ~s_q.tx_full | s_q.tx_buf[0];
          s_d.tx_sr = {2'b11, s_q.tx_buf[7:1] | {7{~s_q.tx_full}}};
        end
      end
      else if (samp)
      begin
        s_d.sy_sr = {s_q.rx_s2, s_q.sy_sr[7:1]};
        s_d.sy_bits = s_q.sy_bits + 4'h1;
        if (s_q.sy_bits + 4'h1 == SYNC_BITS)
        begin
          s_d.sy_act = 1'b0;
          xfer = s_q.mode[MB_RXE];
          xword = {1'b0, s_q.rx_s2, s_q.sy_sr[7:1]};
          if (s_q.sy_tx)
          begin
            s_d.tx_full = 1'b0;
            s_d.tx_irq = 1'b1;
          end
        end
      end
      else if (shft && s_q.sy_bits != 4'h0)
      begin
        s_d.tx_pin = s_q.tx_sr[0];
        s_d.tx_sr = {1'b1, s_q.tx_sr[8:1]};
      end
    end
    // =======================================================
    // register port and receive buffer
    rd_buf = reg_rd && reg_addr == ADDR_DATA;
    if (rd_buf)
      s_d.rx_full = 1'b0;
    if (reg_rd && reg_addr == ADDR_CTRL)
      s_d.oerr = 1'b0;
    if (xfer)
    begin
      if (s_q.rx_full && !rd_buf)
        s_d.oerr = 1'b1;
      else
      begin
        s_d.rx_buf = xword[7:0];
        s_d.ninth = xword[8];
        s_d.rx_full = 1'b1;
        s_d.rx_irq = !(mode == MODE_9 && s_q.mode[MB_WU] && !xword[8]);
      end
    end
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_DATA:
        begin
          s_d.tx_buf = reg_wdata;
          s_d.tx_full = 1'b1;
        end
        ADDR_CTRL: s_d.ctrl = reg_wdata & CTRL_WMASK;
        ADDR_MODE: s_d.mode = reg_wdata;
        ADDR_BRCR: s_d.brcr = reg_wdata;
        ADDR_BRADD: s_d.bradd = reg_wdata[3:0];
        default: ;
      endcase
    end
    s_d.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_DATA: s_d.rdata = s_q.rx_buf;
        ADDR_CTRL: s_d.rdata = {s_q.ninth, 1'b0, s_q.ctrl[CB_PE], s_q.oerr,
                                2'b00, s_q.ctrl[CB_EDGE], s_q.ctrl[CB_DIR]};
        ADDR_MODE: s_d.rdata = s_q.mode;
        ADDR_BRCR: s_d.rdata = s_q.brcr;
        ADDR_BRADD: s_d.rdata = {4'h0, s_q.bradd};
        ADDR_STAT: s_d.rdata = {5'h00, s_q.rx_full, s_q.tx_full,
                                (s_q.tx_st != TX_IDLE) | s_q.sy_act};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // state register, idle line levels high
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.mode <= REG_RST;
      s_q.ctrl <= REG_RST;
      s_q.tx_pin <= 1'b1;
      s_q.sclk_o <= 1'b1;
      s_q.rx_s1 <= 1'b1;
      s_q.rx_s2 <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // outputs straight from state flops
  assign reg_rdata = s_q.rdata;
  assign serial_clock_pin_o = s_q.sclk_o;
  assign serial_clock_pin_oe = s_q.sclk_oe;
  assign tx_pin = s_q.tx_pin;
  assign rx_irq = s_q.rx_irq;
  assign tx_irq = s_q.tx_irq;

  // =========================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_irq_pulse;
    (rx_irq |=> !rx_irq) and (tx_irq |=> !tx_irq);
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
  property p_rx_irq_cause;
    rx_irq |-> $past(xfer) && s_q.rx_full;
  endproperty
  a_rx_irq_cause: assert property (p_rx_irq_cause) else $error("rx irq");
  property p_overrun;
    xfer && s_q.rx_full && !(reg_rd && reg_addr == ADDR_DATA)
      |=> s_q.oerr && $stable(s_q.rx_buf) && $stable(s_q.ninth) && !rx_irq;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun");
  property p_wakeup;
    rx_irq && s_q.mode[3:2] == MODE_9 && s_q.mode[MB_WU] |-> s_q.ninth;
  endproperty
  a_wakeup: assert property (p_wakeup) else $error("wakeup leak");
  property p_start_low;
    s_q.tx_st == TX_START && $past(s_q.tx_st) == TX_IDLE |-> !tx_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit");
  property p_cts_hold;
    s_q.tx_st == TX_IDLE && s_q.mode[MB_HS] && s_q.cts_s2
      |=> s_q.tx_st == TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("cts ignored");
  property p_tx_empty;
    $fell(s_q.tx_full) && !reg_wr |-> tx_irq;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty");
  property p_sclk_half;
    s_q.sclk_oe && s_q.sy_act && $changed(serial_clock_pin_o)
      |-> $past(s_q.brg_tick);
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk rate");
  property p_sclk_input;
    s_q.ctrl[CB_DIR] |=> !serial_clock_pin_oe;
  endproperty
  a_sclk_input: assert property (p_sclk_input) else $error("sclk drive");
  property p_no_timer_sync;
    s_q.mode[3:2] == MODE_SYNC
      |=> $stable(s_q.rx_cnt) && $stable(s_q.tx_cnt);
  endproperty
  a_no_timer_sync: assert property (p_no_timer_sync) else $error("base");
  c_rx_word: cover property (rx_irq);
  c_tx_word: cover property (tx_irq);
  c_overrun: cover property ($rose(s_q.oerr));
  c_held: cover property ($fell(s_q.tx_held));
endmodule : dmsc_serial_channel
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench for the dual mode serial channel
// Assumes: ticks made here, peer model on the line side
// Notes: drivers queue expected results, one monitor checks them
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmsc_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr, reg_rd;
  logic rd_d1 = 1'b0;
  logic presc_tick, io_tick, timer_match_tick;
  logic sclk_in;
  logic link_run = 1'b0;
  logic listen;
  logic tb_drive = 1'b0;
  logic tb_rx = 1'b1;
  logic [9:0] bit_cyc;
  logic [7:0] reg_rdata, word, d, e;
  logic peer_rx, sclk_o, sclk_oe, cts_n, tx_pin, rx_irq, tx_irq, word_valid;
  wire logic dut_rx;
  logic [31:0] rnd = 32'ha6e8b393;
  logic [15:0] q_rd[$];
  logic [7:0] q_pw[$];
  bit q_rx[$];
  bit q_tx[$];
  int n_errors = 0;
  int n_tests = 0;
  int cnt = 0;
  int n;
  logic [1:0] srcs [6] = '{SRC_IO, SRC_TIMER, SRC_BRG, SRC_BRG, SRC_BRG,
                           SRC_EXT};
  logic [7:0] brs [6] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h42, 8'h02};
  logic [7:0] ks [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00};
  logic [9:0] cycs [6] = '{10'h020, 10'h030, 10'h040, 10'h200, 10'h050,
                           10'h080};

  // =========================================================
  // clock, ticks, link clock, wiring
  always #12.5 clk_sys = ~clk_sys;

  // prescaler and io ticks every second cycle, timer every third
  always @(posedge clk_sys)
  begin
    cnt <= cnt + 1;
    presc_tick <= cnt[0];
    io_tick <= cnt[0];
    timer_match_tick <= (cnt % 3 == 0);
  end

  // link clock, phase free of clk_sys, runs only when asked
  initial
  begin
    #7;
    forever
    begin
      #100;
      if (link_run)
        sclk_in = ~sclk_in;
    end
  end

  assign dut_rx = tb_drive ? tb_rx : peer_rx;

  dmsc_serial_channel i_dut
  (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .presc_tick(presc_tick), .io_tick(io_tick),
    .timer_match_tick(timer_match_tick), .rx_pin(dut_rx),
    .serial_clock_pin_i(sclk_in), .serial_clock_pin_o(sclk_o),
    .serial_clock_pin_oe(sclk_oe), .clear_to_send_n(cts_n),
    .tx_pin(tx_pin), .rx_irq(rx_irq), .tx_irq(tx_irq)
  );

  dmsc_peer_model p
  (
    .clk_sys(clk_sys), .tx_pin(tx_pin), .listen(listen),
    .bit_cyc(bit_cyc), .rx_pin(peer_rx), .clear_to_send_n(cts_n),
    .word_valid(word_valid), .word(word)
  );

  // =========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic int pend();
    return q_rd.size() + q_pw.size() + q_rx.size() + q_tx.size();
  endfunction : pend

  task automatic roll(output logic [7:0] b);
    rnd = lfsr(rnd);
    b = rnd[7:0];
  endtask : roll

  task automatic bad(input string m);
    n_errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask : bad

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read; only the bits set in m are compared
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] m,
                    input logic [7:0] v);
    q_rd.push_back({m, v});
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic wait_done();
    repeat (12000)
      if (pend() != 0)
        @(posedge clk_sys);
    n_tests++;
    if (pend() != 0)
      bad("result missing");
  endtask : wait_done

  task automatic wait_lvl(input logic v, output int c);
    c = 0;
    while (sclk_o !== v && c < 40)
    begin
      @(negedge clk_sys);
      c++;
    end
  endtask : wait_lvl

  task automatic print_verdict();
    $display("errors %0d, checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // =========================================================
  // monitor: each result takes the oldest note of its kind
  always @(posedge clk_sys)
  begin
    rd_d1 <= reg_rd;
    if (rd_d1 === 1'b1)
    begin
      n_tests++;
      if (q_rd.size() == 0 || (reg_rdata & q_rd[0][15:8]) !== q_rd[0][7:0])
        bad("read data");
      if (q_rd.size() != 0)
        void'(q_rd.pop_front());
    end
    if (word_valid === 1'b1)
    begin
      n_tests++;
      if (q_pw.size() == 0 || word !== q_pw[0])
        bad("peer word");
      if (q_pw.size() != 0)
        void'(q_pw.pop_front());
    end
    if (rx_irq === 1'b1)
    begin
      n_tests++;
      if (q_rx.size() == 0)
        bad("rx irq");
      else
        void'(q_rx.pop_front());
    end
    if (tx_irq === 1'b1)
    begin
      n_tests++;
      if (q_tx.size() == 0)
        bad("tx irq");
      else
        void'(q_tx.pop_front());
    end
  end

  // watchdog against a hung wait
  initial
  begin
    #2000000;
    n_errors++;
    print_verdict();
  end

  // =========================================================
  // main sequence
  initial
  begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sclk_in = 1'b0;
    listen = 1'b1;
    bit_cyc = 10'h020;
    // reset acts at the first clock edge, look after it
    @(negedge clk_sys);
    n_tests++;
    if (tx_pin !== 1'b1 || sclk_o !== 1'b1 || sclk_oe !== 1'b0 ||
        rx_irq !== 1'b0 || tx_irq !== 1'b0)
      bad("reset levels");
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ADDR_MODE, 8'hff, REG_RST);
    rd(3'h6, 8'hff, 8'h00);
    // every base clock source, integer and fractional rates
    for (int i = 0; i < 6; i++)
    begin
      link_run = (srcs[i] == SRC_EXT);
      bit_cyc = cycs[i];
      wr(ADDR_BRCR, brs[i]);
      wr(ADDR_BRADD, ks[i]);
      wr(ADDR_MODE, {4'h2, MODE_8, srcs[i]});
      roll(d);
      q_rx.push_back(1'b1);
      p.send({1'b0, d}, 1'b0);
      rd(ADDR_DATA, 8'hff, d);
      roll(d);
      q_pw.push_back(d);
      q_tx.push_back(1'b1);
      wr(ADDR_DATA, d);
      wait_done();
    end
    link_run = 1'b0;
    sclk_in = 1'b0;
    bit_cyc = 10'h020;
    wr(ADDR_BRCR, 8'h02);
    wr(ADDR_MODE, {4'h2, MODE_8, SRC_IO});
    // short dip, then overrun by two unread words
    p.dip(3);
    repeat (400) @(posedge clk_sys);
    rd(ADDR_STAT, 8'h04, 8'h00);
    roll(d);
    roll(e);
    q_rx.push_back(1'b1);
    p.send({1'b0, d}, 1'b0);
    p.send({1'b0, e}, 1'b0);
    rd(ADDR_CTRL, 8'h10, 8'h10);
    rd(ADDR_DATA, 8'hff, d);
    rd(ADDR_CTRL, 8'h10, 8'h00);
    // nine bit frames through the wakeup filter
    wr(ADDR_MODE, {4'h3, MODE_9, SRC_IO});
    roll(d);
    p.send({1'b0, d}, 1'b1);
    rd(ADDR_CTRL, 8'h80, 8'h00);
    rd(ADDR_DATA, 8'hff, d);
    roll(e);
    q_rx.push_back(1'b1);
    p.send({1'b1, e}, 1'b1);
    rd(ADDR_CTRL, 8'h80, 8'h80);
    rd(ADDR_DATA, 8'hff, e);
    // seven bit frames, then eight bits with parity in the ninth flag
    wr(ADDR_MODE, {4'h2, MODE_7, SRC_IO});
    roll(d);
    q_rx.push_back(1'b1);
    p.send({2'b01, d[6:0]}, 1'b0);
    rd(ADDR_DATA, 8'hff, {1'b0, d[6:0]});
    wr(ADDR_CTRL, 8'h20);
    wr(ADDR_MODE, {4'h2, MODE_8, SRC_IO});
    q_rx.push_back(1'b1);
    p.send({1'b1, d}, 1'b1);
    rd(ADDR_CTRL, 8'ha0, 8'ha0);
    rd(ADDR_DATA, 8'hff, d);
    wr(ADDR_CTRL, 8'h00);
    // handshake: held word waits, goes once released
    wr(ADDR_MODE, {4'h6, MODE_8, SRC_IO});
    p.set_hold(1'b1);
    repeat (8) @(posedge clk_sys);
    roll(d);
    q_pw.push_back(d);
    q_tx.push_back(1'b1);
    wr(ADDR_DATA, d);
    n = 0;
    repeat (600)
    begin
      @(posedge clk_sys);
      n += (tx_pin !== 1'b1);
    end
    n_tests++;
    if (n != 0)
      bad("sent while held");
    rd(ADDR_STAT, 8'h02, 8'h02);
    p.set_hold(1'b0);
    wait_done();
    // shift mode, own clock, timer source must not matter
    listen = 1'b0;
    wr(ADDR_BRCR, 8'h04);
    wr(ADDR_MODE, {4'h0, MODE_SYNC, SRC_TIMER});
    roll(d);
    q_tx.push_back(1'b1);
    wr(ADDR_DATA, d);
    n_tests++;
    if (sclk_oe !== 1'b1)
      bad("clock not driven");
    for (int k = 0; k < 8; k++)
    begin
      wait_lvl(1'b0, n);
      wait_lvl(1'b1, n);
      n_tests++;
      if (n != 8 || tx_pin !== d[k])
        bad("shift out");
    end
    wait_done();
    // shift mode, clock from the pin, receive only
    wr(ADDR_CTRL, 8'h01);
    wr(ADDR_MODE, {4'h2, MODE_SYNC, SRC_TIMER});
    roll(d);
    q_rx.push_back(1'b1);
    tb_drive = 1'b1;
    #5;
    for (int k = 0; k < 8; k++)
    begin
      tb_rx = d[k];
      #100 sclk_in = 1'b1;
      #100 sclk_in = 1'b0;
    end
    repeat (20) @(posedge clk_sys);
    rd(ADDR_DATA, 8'hff, d);
    wait_done();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
